// ==== hdl/cmd_status_pkg.sv ====
// constants for the configuration command and status register block
// assumes one core clock and a configuration access port on that clock
`default_nettype none

package cmd_status_pkg;
  // configuration byte offsets
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] STS_OFS = 8'h06;
  // command bit positions
  localparam int CMD_IO = 0;
  localparam int CMD_MEM = 1;
  localparam int CMD_BM = 2;
  localparam int CMD_MWI = 4;
  localparam int CMD_PER = 6;
  localparam int CMD_SERR = 8;
  // status bit positions
  localparam int STS_CAP = 4;
  localparam int STS_66 = 5;
  localparam int STS_B2B = 7;
  localparam int STS_MPAR = 8;
  localparam int STS_TIM_LO = 9;
  localparam int STS_TSENT = 11;
  localparam int STS_TGOT = 12;
  localparam int STS_MGOT = 13;
  localparam int STS_SERR = 14;
  localparam int STS_PAR = 15;
  // field values and reset values
  localparam logic [1:0] SEL_TIMING = 2'h1;
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [15:0] STS_RST = 16'h0000;
  localparam logic [15:0] STS_W1C = 16'hf900;
  // bus command codes for master writes
  localparam logic [3:0] BUS_MEM_WR = 4'h7;
  localparam logic [3:0] BUS_MEM_WRINV = 4'hf;
  // select delay in clocks after frame start
  localparam int SEL_DLY = 2;

  // target select sequencer
  typedef enum logic [1:0] {
    SEL_IDLE = 2'b00,
    SEL_WAIT = 2'b01,
    SEL_ON = 2'b10
  } sel_state_t;
endpackage

`default_nettype wire

// ==== hdl/pci_cmd_status_regs.sv ====
// command and status registers with decode, master and error gating
// assumes the bus engine gives same-clock event pulses; the parity pin is external
`default_nettype none

module pci_cmd_status_regs (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  output logic cfg_rvalid,
  // option straps from the configuration store
  input wire logic b2b_opt,
  input wire logic pm_opt,
  // target side events
  input wire logic frame_start,
  input wire logic hit_mem,
  input wire logic hit_io,
  input wire logic txn_done,
  input wire logic tgt_data_par_err,
  input wire logic addr_par_err,
  input wire logic tgt_abort_sent,
  // master side events
  input wire logic mst_active,
  input wire logic mst_data_par_err,
  input wire logic mst_req,
  input wire logic mst_wrinv_want,
  input wire logic mst_master_abort,
  input wire logic mst_target_abort,
  // pins
  input wire logic perr_in_n,
  output logic perr_out_n,
  output logic perr_oe,
  output logic serr_out_n,
  output logic serr_oe,
  output logic devsel_out_n,
  output logic devsel_oe,
  // engine controls
  output logic mem_space_en,
  output logic io_space_en,
  output logic bus_master_en,
  output logic mst_req_ok,
  output logic [3:0] mst_wr_cmd
);

  logic [15:0] cmd_ff, nxt_cmd;
  logic [15:0] sts_ff, nxt_sts;
  logic [15:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic perr_s1_ff, perr_s2_ff;
  logic perr_oe_ff, nxt_perr_oe;
  logic serr_oe_ff, nxt_serr_oe;
  logic req_ff, nxt_req;
  logic [3:0] wcmd_ff, nxt_wcmd;
  cmd_status_pkg::sel_state_t sel_ff, nxt_sel;
  logic sel_oe_ff, nxt_sel_oe;
  logic perr_n_ff, nxt_perr_n;
  logic serr_n_ff, nxt_serr_n;
  logic sel_n_ff, nxt_sel_n;
  logic per_en, hit, cmd_wr, sts_wr;
  logic [15:0] sts_view;

  // byte-lane write mask for 16-bit registers
  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  assign per_en = cmd_ff[cmd_status_pkg::CMD_PER];
  assign cmd_wr = cfg_wr && (cfg_addr == cmd_status_pkg::CMD_OFS);
  assign sts_wr = cfg_wr && (cfg_addr == cmd_status_pkg::STS_OFS);
  // special cycles are never a hit
  assign hit = (hit_mem && cmd_ff[cmd_status_pkg::CMD_MEM])
    || (hit_io && cmd_ff[cmd_status_pkg::CMD_IO]);

  // command register: only implemented bits are writable
  always_comb begin
    logic [15:0] wmask;
    wmask = lane_mask(cfg_be);
    nxt_cmd = cmd_ff;
    if (cmd_wr) begin
      nxt_cmd[cmd_status_pkg::CMD_IO] = wmask[0] ? cfg_wdata[0] : cmd_ff[0];
      nxt_cmd[cmd_status_pkg::CMD_MEM] = wmask[1] ? cfg_wdata[1] : cmd_ff[1];
      nxt_cmd[cmd_status_pkg::CMD_BM] = wmask[2] ? cfg_wdata[2] : cmd_ff[2];
      nxt_cmd[cmd_status_pkg::CMD_MWI] = wmask[4] ? cfg_wdata[4] : cmd_ff[4];
      nxt_cmd[cmd_status_pkg::CMD_PER] = wmask[6] ? cfg_wdata[6] : cmd_ff[6];
      nxt_cmd[cmd_status_pkg::CMD_SERR] = wmask[8] ? cfg_wdata[8] : cmd_ff[8];
    end
  end

  // sticky status: events set, write one clears, set wins
  always_comb begin
    logic [15:0] clr, set;
    clr = sts_wr ? (cfg_wdata & lane_mask(cfg_be) & cmd_status_pkg::STS_W1C) : 16'h0000;
    set = 16'h0000;
    set[cmd_status_pkg::STS_PAR] = tgt_data_par_err || mst_data_par_err
      || addr_par_err;
    set[cmd_status_pkg::STS_SERR] = nxt_serr_oe;
    set[cmd_status_pkg::STS_MGOT] = mst_master_abort;
    set[cmd_status_pkg::STS_TGOT] = mst_target_abort;
    set[cmd_status_pkg::STS_TSENT] = tgt_abort_sent;
    set[cmd_status_pkg::STS_MPAR] = per_en && mst_active
      && (mst_data_par_err || !perr_s2_ff);
    nxt_sts = ((sts_ff & ~clr) | set) & cmd_status_pkg::STS_W1C;
  end

  // read view with constant and option bits; reserved bits zero
  always_comb begin
    sts_view = sts_ff;
    sts_view[cmd_status_pkg::STS_TIM_LO +: 2] = cmd_status_pkg::SEL_TIMING;
    sts_view[cmd_status_pkg::STS_B2B] = b2b_opt;
    sts_view[cmd_status_pkg::STS_66] = 1'b1;
    sts_view[cmd_status_pkg::STS_CAP] = pm_opt;
    nxt_rvalid = cfg_rd;
    nxt_rdata = rdata_ff;
    if (cfg_rd) begin
      if (cfg_addr == cmd_status_pkg::CMD_OFS) begin
        nxt_rdata = cmd_ff;
      end else if (cfg_addr == cmd_status_pkg::STS_OFS) begin
        nxt_rdata = sts_view;
      end else begin
        nxt_rdata = 16'h0000;
      end
    end
  end

  // error pins: parity and system error drive
  always_comb begin
    nxt_perr_oe = per_en && (tgt_data_par_err || mst_data_par_err);
    nxt_serr_oe = cmd_ff[cmd_status_pkg::CMD_SERR] && addr_par_err;
    nxt_perr_n = !nxt_perr_oe; // driven level is low
    nxt_serr_n = !nxt_serr_oe;
  end

  // master request gating and write command choice
  always_comb begin
    nxt_req = mst_req && cmd_ff[cmd_status_pkg::CMD_BM];
    nxt_wcmd = (mst_wrinv_want && cmd_ff[cmd_status_pkg::CMD_MWI])
      ? cmd_status_pkg::BUS_MEM_WRINV : cmd_status_pkg::BUS_MEM_WR;
  end

  // target select: two clocks after frame start on an enabled hit
  always_comb begin
    nxt_sel = sel_ff;
    nxt_sel_oe = sel_oe_ff;
    case (sel_ff)
      cmd_status_pkg::SEL_IDLE: begin
        if (frame_start && hit) begin
          nxt_sel = cmd_status_pkg::SEL_WAIT;
        end
      end
      cmd_status_pkg::SEL_WAIT: begin
        nxt_sel = cmd_status_pkg::SEL_ON;
        nxt_sel_oe = 1'b1;
      end
      cmd_status_pkg::SEL_ON: begin
        if (txn_done) begin
          nxt_sel = cmd_status_pkg::SEL_IDLE;
          nxt_sel_oe = 1'b0;
        end
      end
      default: begin
        nxt_sel = cmd_status_pkg::SEL_IDLE;
        nxt_sel_oe = 1'b0;
      end
    endcase
    nxt_sel_n = !nxt_sel_oe;
  end

  // parity pin synchroniser
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      perr_s1_ff <= 1'b1;
      perr_s2_ff <= 1'b1;
    end else begin
      perr_s1_ff <= perr_in_n;
      perr_s2_ff <= perr_s1_ff;
    end
  end

  // state registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cmd_ff <= cmd_status_pkg::CMD_RST;
      sts_ff <= cmd_status_pkg::STS_RST;
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
      perr_oe_ff <= 1'b0;
      serr_oe_ff <= 1'b0;
      req_ff <= 1'b0;
      wcmd_ff <= cmd_status_pkg::BUS_MEM_WR;
      sel_ff <= cmd_status_pkg::SEL_IDLE;
      sel_oe_ff <= 1'b0;
      perr_n_ff <= 1'b1;
      serr_n_ff <= 1'b1;
      sel_n_ff <= 1'b1;
    end else begin
      cmd_ff <= nxt_cmd;
      sts_ff <= nxt_sts;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      perr_oe_ff <= nxt_perr_oe;
      serr_oe_ff <= nxt_serr_oe;
      req_ff <= nxt_req;
      wcmd_ff <= nxt_wcmd;
      sel_ff <= nxt_sel;
      sel_oe_ff <= nxt_sel_oe;
      perr_n_ff <= nxt_perr_n;
      serr_n_ff <= nxt_serr_n;
      sel_n_ff <= nxt_sel_n;
    end
  end

  // outputs straight from flops; driven level is low
  assign cfg_rdata = rdata_ff;
  assign cfg_rvalid = rvalid_ff;
  assign perr_oe = perr_oe_ff;
  assign perr_out_n = perr_n_ff;
  assign serr_oe = serr_oe_ff;
  assign serr_out_n = serr_n_ff;
  assign devsel_oe = sel_oe_ff;
  assign devsel_out_n = sel_n_ff;
  assign mem_space_en = cmd_ff[cmd_status_pkg::CMD_MEM];
  assign io_space_en = cmd_ff[cmd_status_pkg::CMD_IO];
  assign bus_master_en = cmd_ff[cmd_status_pkg::CMD_BM];
  assign mst_req_ok = req_ff;
  assign mst_wr_cmd = wcmd_ff;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  perr_drive_a: assert property ((tgt_data_par_err && per_en) |=> perr_oe)
    else $error("parity pin not driven");
  perr_quiet_a: assert property (!per_en && !$past(per_en) |-> !perr_oe)
    else $error("parity pin driven while disabled");
  rsv_cmd_a: assert property (cfg_rvalid && $past(cfg_addr) == cmd_status_pkg::CMD_OFS
    |-> cfg_rdata[5] == 1'b0 && cfg_rdata[3] == 1'b0 && cfg_rdata[15:9] == 7'h00)
    else $error("fixed command bits not zero");
  wrinv_a: assert property (mst_wrinv_want && !cmd_ff[cmd_status_pkg::CMD_MWI]
    |=> mst_wr_cmd == cmd_status_pkg::BUS_MEM_WR)
    else $error("invalidate write used while disabled");
  bm_gate_a: assert property (!cmd_ff[cmd_status_pkg::CMD_BM] |=> !mst_req_ok)
    else $error("master request passed while disabled");
  sel_gate_a: assert property (frame_start && !hit && sel_ff == cmd_status_pkg::SEL_IDLE
    |=> ##1 !devsel_oe)
    else $error("select on a disabled space");
  sel_time_a: assert property (sel_ff == cmd_status_pkg::SEL_IDLE && frame_start && hit
    |=> !devsel_oe ##1 devsel_oe)
    else $error("select not two clocks after frame");
  par_sticky_a: assert property (addr_par_err |=> sts_ff[cmd_status_pkg::STS_PAR])
    else $error("parity status not set");
  serr_flag_a: assert property ($rose(serr_oe) |-> sts_ff[cmd_status_pkg::STS_SERR])
    else $error("system error status not set");
  w1c_only_a: assert property (sts_wr && !mst_master_abort && cfg_be[1]
    && cfg_wdata[cmd_status_pkg::STS_MGOT] |=> !sts_ff[cmd_status_pkg::STS_MGOT])
    else $error("master abort status not cleared");
  mpar_a: assert property (!per_en |=> !$rose(sts_ff[cmd_status_pkg::STS_MPAR]))
    else $error("master parity status set while disabled");

  // decode, select release and pin levels
  io_gate_a: assert property (frame_start && hit_io && !hit_mem && !io_space_en
    && sel_ff == cmd_status_pkg::SEL_IDLE |=> ##1 !devsel_oe)
    else $error("select on a disabled io space");
  sel_rel_a: assert property (sel_ff == cmd_status_pkg::SEL_ON && txn_done
    |=> !devsel_oe && devsel_out_n)
    else $error("select held after transaction end");
  sel_pin_a: assert property (devsel_oe != devsel_out_n)
    else $error("select pin level disagrees with its enable");
  perr_pin_a: assert property (perr_oe != perr_out_n)
    else $error("parity pin level disagrees with its enable");
  serr_pin_a: assert property (serr_oe != serr_out_n)
    else $error("system error pin level disagrees with its enable");

  // reset value and fixed status bits
  per_rst_a: assert property ($fell(sys_rst) |-> !per_en)
    else $error("parity response on after reset");
  sts_fix_a: assert property (cfg_rvalid
    && $past(cfg_addr) == cmd_status_pkg::STS_OFS |-> cfg_rdata[cmd_status_pkg::STS_66]
    && cfg_rdata[cmd_status_pkg::STS_TIM_LO +: 2] == cmd_status_pkg::SEL_TIMING)
    else $error("fixed status bits wrong");
  sts_rsv_a: assert property (cfg_rvalid
    && $past(cfg_addr) == cmd_status_pkg::STS_OFS |-> cfg_rdata[3:0] == 4'h0)
    else $error("reserved status bits not zero");
  udf_zero_a: assert property (cfg_rvalid
    && $past(cfg_addr) == cmd_status_pkg::STS_OFS |-> !cfg_rdata[6])
    else $error("user feature bit not zero");
  opt_bits_a: assert property (cfg_rvalid
    && $past(cfg_addr) == cmd_status_pkg::STS_OFS
    |-> cfg_rdata[cmd_status_pkg::STS_B2B] == $past(b2b_opt))
    else $error("back to back bit does not follow its option");
  cap_bit_a: assert property (cfg_rvalid
    && $past(cfg_addr) == cmd_status_pkg::STS_OFS
    |-> cfg_rdata[cmd_status_pkg::STS_CAP] == $past(pm_opt))
    else $error("capability bit does not follow its option");

  // sticky status set, write never sets
  tgot_set_a: assert property (mst_target_abort |=> sts_ff[cmd_status_pkg::STS_TGOT])
    else $error("received target abort status not set");
  tsent_set_a: assert property (tgt_abort_sent |=> sts_ff[cmd_status_pkg::STS_TSENT])
    else $error("signalled target abort status not set");
  wr_no_set_a: assert property (sts_wr && !tgt_abort_sent
    |=> !$rose(sts_ff[cmd_status_pkg::STS_TSENT]))
    else $error("status bit set by a write");
  mpar_set_a: assert property (per_en && mst_active && mst_data_par_err
    |=> sts_ff[cmd_status_pkg::STS_MPAR])
    else $error("master parity status not set");

  // master controls pass when enabled
  wrinv_on_a: assert property (mst_wrinv_want && cmd_ff[cmd_status_pkg::CMD_MWI]
    |=> mst_wr_cmd == cmd_status_pkg::BUS_MEM_WRINV)
    else $error("invalidate write not used while enabled");
  bm_pass_a: assert property (mst_req && bus_master_en |=> mst_req_ok)
    else $error("master request blocked while enabled");

endmodule

`default_nettype wire

// ==== dv/bus_agent.sv ====
// far side agent on the parity pin, with the pin pull-up
// assumes the bench asks for a pull by holding agent_pull high
`default_nettype none
module bus_agent (
  // bench request
  input wire logic agent_pull,
  // device drive of the pin
  input wire logic perr_out_n,
  input wire logic perr_oe,
  // wired pin level
  output logic perr_in_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // both drivers share the wire; released means pulled high
  assign perr_in_n = !((perr_oe && !perr_out_n) || agent_pull);
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the command and status register block
// assumes the bus agent model on the parity pin
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'h0, sys_rst = 1'h1, cfg_wr = 1'h0, cfg_rd = 1'h0, b2b_opt = 1'h0;
  logic pm_opt = 1'h0, frame_start = 1'h0, hit_mem = 1'h0, hit_io = 1'h0, txn_done = 1'h0;
  logic act = 1'h0, pull = 1'h0, mst_req = 1'h0, wrinv = 1'h1;
  logic [7:0] cfg_addr = 8'h00;
  logic [1:0] cfg_be = 2'h0;
  logic [15:0] cfg_wdata = 16'h0000, cfg_rdata, cmd_m, r = 16'h11bc, v;
  logic [5:0] ev = 6'h00;
  logic [15:0] evb [6] = '{16'h0800, 16'h2000, 16'h1000, 16'h8000, 16'h8000, 16'h8000};
  logic cfg_rvalid, perr_in_n, perr_out_n, perr_oe, serr_out_n, serr_oe;
  logic devsel_out_n, devsel_oe, mem_space_en, io_space_en, bus_master_en, mst_req_ok;
  logic [3:0] mst_wr_cmd;
  int mismatches = 0, samples_checked = 0;

  // device and far side
  pci_cmd_status_regs dut (.core_clk(core_clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .b2b_opt(b2b_opt), .pm_opt(pm_opt),
    .frame_start(frame_start), .hit_mem(hit_mem), .hit_io(hit_io), .txn_done(txn_done),
    .tgt_data_par_err(ev[3]), .addr_par_err(ev[4]), .tgt_abort_sent(ev[0]),
    .mst_active(ev[5] | act), .mst_data_par_err(ev[5]), .mst_req(mst_req),
    .mst_wrinv_want(wrinv), .mst_master_abort(ev[1]), .mst_target_abort(ev[2]),
    .perr_in_n(perr_in_n), .perr_out_n(perr_out_n), .perr_oe(perr_oe),
    .serr_out_n(serr_out_n), .serr_oe(serr_oe), .devsel_out_n(devsel_out_n),
    .devsel_oe(devsel_oe), .mem_space_en(mem_space_en), .io_space_en(io_space_en),
    .bus_master_en(bus_master_en), .mst_req_ok(mst_req_ok), .mst_wr_cmd(mst_wr_cmd));
  bus_agent agent (.agent_pull(pull), .perr_out_n(perr_out_n), .perr_oe(perr_oe),
    .perr_in_n(perr_in_n));

  // 25 MHz clock
  always #20 core_clk = !core_clk;

  // helpers for stimulus and expectations
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cw(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    cfg_wr = 1'h1;
    tick();
    cfg_wr = 1'h0;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    cfg_addr = a;
    cfg_rd = 1'h1;
    tick();
    cfg_rd = 1'h0;
    chk({15'h0, cfg_rvalid}, 16'h0001);
    chk(cfg_rdata, exp);
    tick();
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [15:0] fix();
    return 16'h0220 | {8'h00, b2b_opt, 2'h0, pm_opt, 4'h0};
  endfunction
  function automatic logic [15:0] cmd_next(input logic [15:0] o, input logic [1:0] be,
                                           input logic [15:0] d);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}};
    return (o & ~m) | (d & m & 16'h0157);
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (4000) @(posedge core_clk);
    mismatches++;
    test_done();
  end

  // main sequence
  initial begin
    repeat (8) tick();
    sys_rst = 1'h0;
    tick();
    rd(8'h04, 16'h0000);
    rd(8'h06, fix());
    chk({12'h0, mst_wr_cmd}, 16'h0007);
    cw(8'h08, 2'h3, 16'hffff);
    rd(8'h08, 16'h0000);
    rd(8'h04, 16'h0000);
    cw(8'h04, 2'h3, 16'hffff);
    rd(8'h04, 16'h0157);
    $display("test reset done");
    cmd_m = 16'h0157;
    repeat (12) begin
      r = lfsr(r);
      b2b_opt = r[5];
      pm_opt = r[9];
      cw(8'h04, r[1:0], r);
      cmd_m = cmd_next(cmd_m, r[1:0], r);
      rd(8'h04, cmd_m);
      chk({13'h0, bus_master_en, mem_space_en, io_space_en}, {13'h0, cmd_m[2:0]});
      mst_req = r[7];
      wrinv = r[11];
      tick();
      v = {11'h0, r[7] & cmd_m[2], (cmd_m[4] && r[11]) ? 4'hf : 4'h7};
      chk({11'h0, mst_req_ok, mst_wr_cmd}, v);
      cw(8'h06, r[3:2], r);
      rd(8'h06, fix());
    end
    $display("test random done");
    for (int i = 0; i < 8; i++) begin
      cw(8'h04, 2'h3, {14'h0, i[1:0]});
      hit_mem = i[2];
      hit_io = !i[2];
      frame_start = 1'h1;
      tick();
      frame_start = 1'h0;
      chk({15'h0, devsel_oe}, 16'h0000);
      tick();
      v = {14'h0, {2{i[2] ? i[1] : i[0]}}};
      chk({14'h0, devsel_oe, !devsel_out_n}, v);
      txn_done = 1'h1;
      tick();
      txn_done = 1'h0;
      chk({15'h0, devsel_oe}, 16'h0000);
    end
    $display("test select done");
    for (int p = 0; p < 2; p++) begin
      cw(8'h04, 2'h3, p ? 16'h0140 : 16'h0000);
      for (int k = 0; k < 6; k++) begin
        ev = 6'h01 << k;
        tick();
        ev = 6'h00;
        v = {14'h0, p != 0 && (k == 3 || k == 5), p != 0 && k == 4};
        chk({14'h0, perr_oe, serr_oe}, v);
        chk({14'h0, !perr_out_n, !serr_out_n}, v);
        v = fix() | evb[k] | (p && k == 4 ? 16'h4000 : 16'h0) | (p && k == 5 ? 16'h0100 : 16'h0);
        rd(8'h06, v);
        cw(8'h06, 2'h3, 16'hffff);
      end
      act = 1'h1;
      pull = 1'h1;
      repeat (4) tick();
      pull = 1'h0;
      act = 1'h0;
      tick();
      rd(8'h06, fix() | (p ? 16'h0100 : 16'h0));
      cw(8'h06, 2'h3, 16'hffff);
    end
    ev = 6'h03;
    tick();
    ev = 6'h00;
    cw(8'h06, 2'h1, 16'hffff);
    cw(8'h06, 2'h2, 16'h0800);
    rd(8'h06, fix() | 16'h2000);
    $display("test errors done");
    test_done();
  end
endmodule
`default_nettype wire
